/* rtl/tsrb_pkg.sv */
package tsrb_pkg;

  // register indices selected by the pointer
  localparam logic [7:0] IDX_CAPABILITY = 8'h00;
  localparam logic [7:0] IDX_CONFIG     = 8'h01;
  localparam logic [7:0] IDX_UPPER      = 8'h02;
  localparam logic [7:0] IDX_LOWER      = 8'h03;
  localparam logic [7:0] IDX_CRITICAL   = 8'h04;
  localparam logic [7:0] IDX_TEMP       = 8'h05;
  localparam logic [7:0] IDX_MAKER      = 8'h06;
  localparam logic [7:0] IDX_PART       = 8'h07;
  localparam logic [7:0] IDX_BUS_CTRL   = 8'h22;

  // reset values
  localparam logic [7:0]  RST_INDEX     = 8'h00;
  localparam logic [15:0] RST_CAPABILITY = 16'h0015;
  localparam logic [15:0] RST_WORD      = 16'h0000;

  // configuration field positions
  localparam int CFG_HYST_LO  = 9;
  localparam int CFG_SHUTDOWN = 8;
  localparam int CFG_CRIT_LCK = 7;
  localparam int CFG_WIN_LCK  = 6;
  localparam logic [15:0] CFG_WRITABLE = 16'h07ff;

  // identification words, values arbitrary
  localparam logic [15:0] MAKER_ID_VALUE = 16'h0a5a;
  localparam logic [15:0] PART_ID_VALUE  = 16'h0b01;

  typedef enum logic [1:0]
  {
    TSRB_IDLE  = 2'b00,
    TSRB_WRITE = 2'b01,
    TSRB_READ  = 2'b10
  } tsrb_op_t;

  typedef struct packed
  {
    logic        hyst_en;
    logic [1:0]  hysteresis;
    logic        shutdown;
    logic [7:0]  event_ctrl;
  } tsrb_cfg_t;

endpackage : tsrb_pkg

/* rtl/tsrb_cfg_merge.sv */
module tsrb_cfg_merge
  import tsrb_pkg::*;
(
  // current and requested words
  input  wire logic [15:0] cur_in,
  input  wire logic [15:0] wr_in,
  // merged word
  output logic      [15:0] next_out
);

  logic locked;
  logic [15:0] merged;

  always_comb
  begin
    locked = cur_in[CFG_CRIT_LCK] | cur_in[CFG_WIN_LCK];
    merged = wr_in & CFG_WRITABLE;                      // [R13] [R20]
    if (locked)
    begin
      merged[CFG_HYST_LO+1 -: 2] = cur_in[CFG_HYST_LO+1 -: 2]; // [R16]
      merged[CFG_SHUTDOWN] = cur_in[CFG_SHUTDOWN] & wr_in[CFG_SHUTDOWN];
    end
    next_out = merged;                                  // [R17]
  end

endmodule : tsrb_cfg_merge

/* rtl/tsrb_bank.sv */
// What this block does
// R1: every data access goes to the register the pointer selects
// R2: reads of write-only registers return zero
// R3: writes to read-only registers are accepted but change nothing
// R4: pointer is 8 bits, all other registers 16 bits
// R5: pointer decode 00h-07h and 22h as listed
// R6: capability resets 0015h; config, limits, bus control reset 0000h
// R7: reserved indices read 0000h; host should not write them
// R8: capability bits 15:5 read zero
// R9: capability resolution field reads binary 10
// R10: capability bit 2 reads one, negative temperatures supported
// R11: capability bit 1 reads zero, standard accuracy
// R12: capability bit 0 reads one, alarm capability present
// R13: configuration bits 15:11 always read zero
// R14: hysteresis field at bits 10:9, default 00
// R15: shutdown bit 8, event control bits 7:0, default zero
// R16: hysteresis codes 00 to 11; field frozen while locked
// R17: shutdown cannot be set while locked, may always be cleared
// R18: pointer resets to 00h and holds the last value written
// R19: host writes two data bytes after the pointer, high first
// R20: read-only bits inside writable registers ignore writes
module tsrb_bank
  import tsrb_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // pointer write
  input  wire logic        index_we_in,
  input  wire logic [7:0]  index_in,
  // data access
  input  wire logic        write_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        read_in,
  output logic      [15:0] rdata_out,
  output logic             ack_out,
  // live sources
  input  wire logic [15:0] temp_in,
  // configuration outputs
  output logic [7:0]       index_out,
  output tsrb_cfg_t        cfg_out,
  output logic [15:0]      upper_out,
  output logic [15:0]      lower_out,
  output logic [15:0]      critical_out,
  output logic [15:0]      bus_ctrl_out
);

  logic        rst_meta;
  logic        rst_sync_n;
  logic [7:0]  register_index;
  logic [15:0] configuration_word;
  logic [15:0] upper_alarm_limit;
  logic [15:0] lower_alarm_limit;
  logic [15:0] critical_alarm_limit;
  logic [15:0] bus_timeout_control;
  logic [15:0] next_config;
  logic [15:0] next_rdata;
  logic        crit_locked;
  logic        win_locked;

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  function automatic logic hits(input logic [7:0] idx,
                                input logic [7:0] target);
    hits = (idx == target);
  endfunction : hits

  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      register_index <= RST_INDEX;                      // [R18]
    else if (index_we_in)
      register_index <= index_in;                       // [R4] [R18]
  end

  tsrb_cfg_merge u_merge
  (
    .cur_in   (configuration_word),
    .wr_in    (wdata_in),
    .next_out (next_config)
  );

  assign crit_locked = configuration_word[CFG_CRIT_LCK];
  assign win_locked  = configuration_word[CFG_WIN_LCK];

  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      configuration_word <= RST_WORD;                   // [R6] [R15]
    else if (write_in && hits(register_index, IDX_CONFIG))
      configuration_word <= next_config;                // [R14] [R15]
  end

  // window limits freeze under window lock, critical under critical lock
  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      upper_alarm_limit    <= RST_WORD;                 // [R6]
      lower_alarm_limit    <= RST_WORD;
      critical_alarm_limit <= RST_WORD;
      bus_timeout_control  <= RST_WORD;
    end
    else if (write_in)
    begin
      if (hits(register_index, IDX_UPPER) && !win_locked)
        upper_alarm_limit <= wdata_in;                  // [R1]
      if (hits(register_index, IDX_LOWER) && !win_locked)
        lower_alarm_limit <= wdata_in;
      if (hits(register_index, IDX_CRITICAL) && !crit_locked)
        critical_alarm_limit <= wdata_in;
      if (hits(register_index, IDX_BUS_CTRL))
        bus_timeout_control <= wdata_in;
    end
  end

  always_comb
  begin
    case (register_index)                               // [R1] [R5]
      IDX_CAPABILITY: next_rdata = RST_CAPABILITY;      // [R8] [R9] [R10] [R11] [R12]
      IDX_CONFIG:     next_rdata = configuration_word;  // [R13]
      IDX_UPPER:      next_rdata = upper_alarm_limit;
      IDX_LOWER:      next_rdata = lower_alarm_limit;
      IDX_CRITICAL:   next_rdata = critical_alarm_limit;
      IDX_TEMP:       next_rdata = temp_in;
      IDX_MAKER:      next_rdata = MAKER_ID_VALUE;
      IDX_PART:       next_rdata = PART_ID_VALUE;
      IDX_BUS_CTRL:   next_rdata = bus_timeout_control;
      default:        next_rdata = RST_WORD;            // [R7] [R2]
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rdata_out <= RST_WORD;
    else if (read_in)
      rdata_out <= next_rdata;
  end

  // every write is acknowledged, read-only ones included
  always_ff @(posedge clock_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ack_out <= 1'b0;
    else
      ack_out <= write_in | read_in | index_we_in;      // [R3]
  end

  assign index_out    = register_index;
  assign cfg_out      = {|configuration_word[10:9],
                         configuration_word[10:9],
                         configuration_word[8],
                         configuration_word[7:0]};
  assign upper_out    = upper_alarm_limit;
  assign lower_out    = lower_alarm_limit;
  assign critical_out = critical_alarm_limit;
  assign bus_ctrl_out = bus_timeout_control;

  sequence s_cap_read;
    read_in && register_index == IDX_CAPABILITY;
  endsequence

  sequence s_cfg_wr_open;
    write_in && register_index == IDX_CONFIG && !crit_locked && !win_locked;
  endsequence

  sequence s_shut_clear;
    write_in && register_index == IDX_CONFIG && !wdata_in[CFG_SHUTDOWN];
  endsequence

  a_cap_value: assert property (                        // [R6]
    @(posedge clock_in) disable iff (!rst_sync_n)
    s_cap_read |=> rdata_out == RST_CAPABILITY)
    else $error("capability word wrong");

  a_cap_rsvd: assert property (                         // [R8]
    @(posedge clock_in) disable iff (!rst_sync_n)
    s_cap_read |=> rdata_out[15:5] == 11'h000)
    else $error("capability reserved bits set");

  a_cap_res: assert property (                          // [R9]
    @(posedge clock_in) disable iff (!rst_sync_n)
    s_cap_read |=> rdata_out[4:3] == 2'h2)
    else $error("capability resolution wrong");

  a_cap_range: assert property (                        // [R10]
    @(posedge clock_in) disable iff (!rst_sync_n)
    s_cap_read |=> rdata_out[2])
    else $error("capability range flag clear");

  a_cap_grade: assert property (                        // [R11]
    @(posedge clock_in) disable iff (!rst_sync_n)
    s_cap_read |=> !rdata_out[1])
    else $error("capability accuracy flag set");

  a_cap_alarm: assert property (                        // [R12]
    @(posedge clock_in) disable iff (!rst_sync_n)
    s_cap_read |=> rdata_out[0])
    else $error("capability alarm flag clear");

  a_rsvd_zero: assert property (                        // [R7]
    @(posedge clock_in) disable iff (!rst_sync_n)
    read_in && register_index > IDX_PART && register_index != IDX_BUS_CTRL
    |=> rdata_out == RST_WORD)
    else $error("reserved index not zero");

  a_cfg_rsvd: assert property (                         // [R13]
    @(posedge clock_in) disable iff (!rst_sync_n)
    configuration_word[15:11] == 5'h00)
    else $error("config reserved bits set");

  a_hyst_lock: assert property (                        // [R16]
    @(posedge clock_in) disable iff (!rst_sync_n)
    (crit_locked || win_locked) |=> $stable(configuration_word[10:9]))
    else $error("hysteresis changed while locked");

  a_shut_lock: assert property (                        // [R17]
    @(posedge clock_in) disable iff (!rst_sync_n)
    (crit_locked || win_locked) && !configuration_word[CFG_SHUTDOWN]
    |=> !configuration_word[CFG_SHUTDOWN])
    else $error("shutdown set while locked");

  a_shut_clear: assert property (                       // [R17]
    @(posedge clock_in) disable iff (!rst_sync_n)
    s_shut_clear |=> !configuration_word[CFG_SHUTDOWN])
    else $error("shutdown not cleared");

  a_cfg_write: assert property (                        // [R15]
    @(posedge clock_in) disable iff (!rst_sync_n)
    s_cfg_wr_open |=> configuration_word == ($past(wdata_in) & CFG_WRITABLE))
    else $error("config write lost");

  a_index_hold: assert property (                       // [R18]
    @(posedge clock_in) disable iff (!rst_sync_n)
    !index_we_in |=> $stable(register_index))
    else $error("pointer drifted");

  a_index_load: assert property (                       // [R18]
    @(posedge clock_in) disable iff (!rst_sync_n)
    index_we_in |=> register_index == $past(index_in))
    else $error("pointer not loaded");

  a_write_ack: assert property (                        // [R3]
    @(posedge clock_in) disable iff (!rst_sync_n)
    write_in |=> ack_out)
    else $error("write not acknowledged");

  a_read_ack: assert property (                         // [R1]
    @(posedge clock_in) disable iff (!rst_sync_n)
    read_in |=> ack_out)
    else $error("read not acknowledged");

  a_ack_idle: assert property (                         // [R3]
    @(posedge clock_in) disable iff (!rst_sync_n)
    !write_in && !read_in && !index_we_in |=> !ack_out)
    else $error("acknowledge without request");

  a_upper_wr: assert property (                         // [R1]
    @(posedge clock_in) disable iff (!rst_sync_n)
    write_in && register_index == IDX_UPPER && !win_locked
    |=> upper_alarm_limit == $past(wdata_in))
    else $error("upper limit write lost");

  a_lower_wr: assert property (                         // [R1]
    @(posedge clock_in) disable iff (!rst_sync_n)
    write_in && register_index == IDX_LOWER && !win_locked
    |=> lower_alarm_limit == $past(wdata_in))
    else $error("lower limit write lost");

  a_crit_wr: assert property (                          // [R1]
    @(posedge clock_in) disable iff (!rst_sync_n)
    write_in && register_index == IDX_CRITICAL && !crit_locked
    |=> critical_alarm_limit == $past(wdata_in))
    else $error("critical limit write lost");

  a_bus_wr: assert property (                           // [R1]
    @(posedge clock_in) disable iff (!rst_sync_n)
    write_in && register_index == IDX_BUS_CTRL
    |=> bus_timeout_control == $past(wdata_in))
    else $error("bus control write lost");

  a_win_freeze: assert property (                       // [R16]
    @(posedge clock_in) disable iff (!rst_sync_n)
    win_locked |=> $stable(upper_alarm_limit) && $stable(lower_alarm_limit))
    else $error("window limit changed while locked");

  a_crit_freeze: assert property (                      // [R16]
    @(posedge clock_in) disable iff (!rst_sync_n)
    crit_locked |=> $stable(critical_alarm_limit))
    else $error("critical limit changed while locked");

  a_rdata_hold: assert property (                       // [R1]
    @(posedge clock_in) disable iff (!rst_sync_n)
    !read_in |=> $stable(rdata_out))
    else $error("read data changed without read");

  a_temp_read: assert property (                        // [R5]
    @(posedge clock_in) disable iff (!rst_sync_n)
    read_in && register_index == IDX_TEMP |=> rdata_out == $past(temp_in))
    else $error("temperature read wrong");
endmodule : tsrb_bank

/* tb/tsrb_host_model.sv */
module tsrb_host_model
  import tsrb_pkg::*;
(
  // clock
  input  wire logic        clock_in,
  // requests
  output logic             index_we_out,
  output logic [7:0]       index_out,
  output logic             write_out,
  output logic [15:0]      wdata_out,
  output logic             read_out,
  // answers
  input  wire logic [15:0] rdata_in,
  input  wire logic        ack_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    index_we_out = 1'b0;
    index_out    = 8'h00;
    write_out    = 1'b0;
    wdata_out    = 16'h0000;
    read_out     = 1'b0;
  end

  task automatic point(input logic [7:0] idx);
    @(posedge clock_in);
    #1;
    index_we_out = 1'b1;
    index_out    = idx;
    @(posedge clock_in);
    #1;
    index_we_out = 1'b0;
    index_out    = ~idx;
  endtask : point

  // whole word, high byte first already assembled
  task automatic put(input logic [7:0] idx, input logic [15:0] d,
                     output logic ack);
    point(idx);
    write_out = 1'b1;
    wdata_out = d;
    @(posedge clock_in);
    #1;
    ack       = ack_in;
    write_out = 1'b0;
    wdata_out = ~d;
  endtask : put

  task automatic get_cur(output logic [15:0] d, output logic ack);
    @(posedge clock_in);
    #1;
    read_out = 1'b1;
    @(posedge clock_in);
    #1;
    d        = rdata_in;
    ack      = ack_in;
    read_out = 1'b0;
  endtask : get_cur
endmodule : tsrb_host_model

/* tb/tsrb_bank_tb.sv */
module tsrb_bank_tb;
  import tsrb_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        iwe, wr, rd, ack;
  logic [7:0]  idx, idx_o;
  logic [15:0] wd, rdat, temp, up, lo, cr, bc;
  tsrb_cfg_t   cfg;
  int          err_total = 0;
  int          n_checks = 0;

  always #5 clock_in = ~clock_in;

  tsrb_bank DUT (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .index_we_in(iwe), .index_in(idx), .write_in(wr), .wdata_in(wd),
    .read_in(rd), .rdata_out(rdat), .ack_out(ack), .temp_in(temp),
    .index_out(idx_o), .cfg_out(cfg), .upper_out(up), .lower_out(lo),
    .critical_out(cr), .bus_ctrl_out(bc));

  tsrb_host_model host (.clock_in(clock_in), .index_we_out(iwe),
    .index_out(idx), .write_out(wr), .wdata_out(wd), .read_out(rd),
    .rdata_in(rdat), .ack_in(ack));

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic chk16(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      err_total++;
    end
  endtask : chk16

  task automatic chk1(input string nm, input logic e, g);
    n_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %b got %b", nm, e, g);
      err_total++;
    end
  endtask : chk1

  task automatic rdc(input logic [7:0] i, input logic [15:0] e);
    logic [15:0] d;
    logic        a;
    host.point(i);
    host.get_cur(d, a);
    chk16("read word", e, d);
    chk1("read ack", 1'b1, a);
  endtask : rdc

  task automatic wrc(input logic [7:0] i, input logic [15:0] d);
    logic a;
    host.put(i, d, a);
    chk1("write ack", 1'b1, a);
  endtask : wrc

  task automatic t_reset;
    logic [15:0] d;
    logic        a;
    reset_n_in = 1'b0;
    repeat (4) @(posedge clock_in);
    #1;
    reset_n_in = 1'b1;
    repeat (2) @(posedge clock_in);
    host.get_cur(d, a);
    chk16("pointer default", RST_CAPABILITY, d);
    chk16("cfg out", 16'h0000, {4'h0, cfg});
    rdc(IDX_CAPABILITY, 16'h0015);
    rdc(IDX_CONFIG, 16'h0000);
    rdc(IDX_UPPER, 16'h0000);
    rdc(IDX_LOWER, 16'h0000);
    rdc(IDX_CRITICAL, 16'h0000);
    rdc(IDX_BUS_CTRL, 16'h0000);
    rdc(IDX_MAKER, MAKER_ID_VALUE);
    rdc(IDX_PART, PART_ID_VALUE);
  endtask : t_reset

  task automatic t_reserved;
    rdc(8'h08, 16'h0000);
    rdc(8'h21, 16'h0000);
    rdc(8'h23, 16'h0000);
    rdc(8'hff, 16'h0000);
  endtask : t_reserved

  task automatic t_rw;
    logic [15:0] d;
    logic        a;
    wrc(IDX_UPPER, 16'h0550);
    wrc(IDX_LOWER, 16'h1f40);
    wrc(IDX_CRITICAL, 16'h05f0);
    wrc(IDX_BUS_CTRL, 16'h0080);
    rdc(IDX_UPPER, 16'h0550);
    rdc(IDX_LOWER, 16'h1f40);
    rdc(IDX_CRITICAL, 16'h05f0);
    rdc(IDX_BUS_CTRL, 16'h0080);
    chk16("index out", 16'h0022, {8'h00, idx_o});
    host.get_cur(d, a);
    chk16("pointer held", 16'h0080, d);
    chk16("upper out", 16'h0550, up);
    chk16("lower out", 16'h1f40, lo);
    chk16("critical out", 16'h05f0, cr);
    chk16("bus ctrl out", 16'h0080, bc);
  endtask : t_rw

  task automatic t_readonly;
    temp = 16'h1f40;
    wrc(IDX_CAPABILITY, 16'hffff);
    rdc(IDX_CAPABILITY, 16'h0015);
    wrc(IDX_TEMP, 16'h0000);
    rdc(IDX_TEMP, 16'h1f40);
    wrc(IDX_MAKER, 16'h0000);
    rdc(IDX_MAKER, MAKER_ID_VALUE);
  endtask : t_readonly

  task automatic t_cfg;
    for (int h = 0; h < 4; h++)
    begin
      wrc(IDX_CONFIG, {5'h00, 2'(h), 9'h009});
      rdc(IDX_CONFIG, {5'h00, 2'(h), 9'h009});
    end
    wrc(IDX_CONFIG, 16'hffff);
    rdc(IDX_CONFIG, 16'h07ff);
    wrc(IDX_CONFIG, 16'h00c0);
    rdc(IDX_CONFIG, 16'h06c0);
    wrc(IDX_CONFIG, 16'h01c0);
    rdc(IDX_CONFIG, 16'h06c0);
    chk16("cfg shutdown", 16'h0000, {15'h0, cfg.shutdown});
    wrc(IDX_UPPER, 16'h1234);
    rdc(IDX_UPPER, 16'h0550);
    wrc(IDX_CRITICAL, 16'h1234);
    rdc(IDX_CRITICAL, 16'h05f0);
    wrc(IDX_CONFIG, 16'h0000);
    rdc(IDX_CONFIG, 16'h0600);
    chk16("cfg out", 16'h0e00, {4'h0, cfg});
    wrc(IDX_CONFIG, 16'h0140);
    rdc(IDX_CONFIG, 16'h0140);
    chk16("cfg shutdown", 16'h0001, {15'h0, cfg.shutdown});
    wrc(IDX_CONFIG, 16'h0040);
    rdc(IDX_CONFIG, 16'h0040);
  endtask : t_cfg

  initial
  begin
    #50us;
    err_total++;
    test_done;
  end

  initial
  begin
    temp = 16'h0000;
    t_reset;
    t_reserved;
    t_rw;
    t_readonly;
    t_cfg;
    t_reset;
    test_done;
  end
endmodule : tsrb_bank_tb
